// >>> qxr_pkg.sv
// Package for the quad continuous read engine: opcodes, counts, states, helpers.
// Assumes a 19-bit byte array behind the engine and SPI mode 0 or 3 on the link.
package qxr_pkg;

  // Opcodes of the two quad-address read commands
  localparam logic [7:0] CMD_QUAD_READ = 8'hEB;
  localparam logic [7:0] CMD_QUAD_READ_ALIGNED = 8'hE7;

  // Phase lengths, as last index of a zero-based clock count
  localparam logic [3:0] CMD_LAST_CNT = 4'h7;
  localparam logic [3:0] ADDR_LAST_CNT = 4'h5;
  localparam logic [3:0] MODE_LAST_CNT = 4'h1;

  // Status register five field positions
  localparam int SR5_ALIGN_BIT = 0;
  localparam int SR5_DUMMY_LSB = 4;
  localparam int SR5_DUMMY_MSB = 6;

  // Largest dummy setting; larger codes behave as this one
  localparam logic [2:0] DUMMY_CODE_MAX = 3'h4;

  // Array geometry and wrap point
  localparam int ARRAY_AW = 19;
  localparam logic [ARRAY_AW-1:0] ARRAY_ADDR_LAST = 19'h7FFFF;
  localparam logic [ARRAY_AW-1:0] ARRAY_ADDR_FIRST = 19'h00000;

  // Mode byte pattern that keeps continuous read mode
  localparam logic [7:0] MODE_CONT_MASK = 8'h30;
  localparam logic [7:0] MODE_CONT_VAL = 8'h20;

  // Reset values
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [7:0] COUNT8_RST = 8'h00;
  localparam logic [15:0] COUNT16_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_START,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } qxr_state_t;

  // Index of the last dummy clock: 2*(code+1) clocks, mode byte included
  function automatic logic [3:0] dummy_last(input logic [2:0] code);
    logic [2:0] c;
    c = (code > DUMMY_CODE_MAX) ? DUMMY_CODE_MAX : code;
    return {c, 1'b1};
  endfunction

  // Sequential array address with wrap to the first byte
  function automatic logic [ARRAY_AW-1:0] next_addr(input logic [ARRAY_AW-1:0] a);
    return (a == ARRAY_ADDR_LAST) ? ARRAY_ADDR_FIRST : a + 19'h00001;
  endfunction

  // Mode byte decode: true keeps continuous read mode
  function automatic logic mode_cont(input logic [7:0] m);
    return (m & MODE_CONT_MASK) == MODE_CONT_VAL;
  endfunction

endpackage

// >>> qxr_io_if.sv
// Interface between the read engine and its quad pad stage.
// Assumes both ends sit in the serial clock domain.
`timescale 1ns/100ps
interface qxr_io_if;
  logic [3:0] nibble;
  logic drive;
  modport engine (output nibble, output drive);
  modport pad (input nibble, input drive);
endinterface

// >>> qxr_sync2.sv
// Two-flop level synchroniser for a small bundle of quasi-static bits.
// Assumes each bit changes rarely relative to the destination clock.
`timescale 1ns/100ps
module qxr_sync2 #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk,
  // Source levels and synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end

endmodule

// >>> qxr_io_pad.sv
// Quad pad output stage: launches nibbles on the falling serial clock edge.
// Assumes chip select high clears the stage at once, without a clock.
`timescale 1ns/100ps
module qxr_io_pad
  import qxr_pkg::*;
(
  // Link clock and chip select
  input wire logic sck,
  input wire logic cs_n_pin,
  // Engine side
  qxr_io_if.pad io,
  // Pad side
  output logic [3:0] quad_io_out,
  output logic [3:0] quad_io_oe
);

  // Falling edge launch gives the host a half period of setup
  always_ff @(negedge sck or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      quad_io_out <= NIBBLE_RST;
      quad_io_oe <= NIBBLE_RST;
    end else begin
      quad_io_out <= io.nibble;
      quad_io_oe <= {4{io.drive}};
    end
  end

endmodule

// >>> qxr_read_engine.sv
// Quad continuous read engine: command, quad address, mode byte, dummy, data.
// Assumes a combinational array read port settling within one serial clock,
// a host in SPI mode 0 or 3, and config held steady while a frame runs.
//
// Contract
// - General quad read takes four address bits per clock on four lines.
// - Aligned quad read forces the two lowest address bits to zero.
// - General quad read is aligned or not per doubleword_align_flag.
// - Command on the serial input line only; later phases use four lines.
// - In continuous read mode a frame starts straight with the address.
// - An eight-bit mode_byte follows the address and decides continuation.
// - Command byte takes eight clocks, most significant bit first.
// - Address takes six clocks, top nibble first, bit three on io3_hold_pin.
// - After the dummy period all four lines turn to outputs.
// - Each byte goes out in two clocks, upper nibble first, bit 7 on io3.
// - Chip select high ends the read and floats all four lines.
// - After the last array byte reading continues at address zero.
// - Dummy clocks set by dummy_cycle_count, status register five bits 6:4.
// - doubleword_align_flag is bit 0; honoured by general, ignored by aligned.
// - The dummy count includes the two mode_byte clocks.
`timescale 1ns/100ps
module qxr_read_engine
  import qxr_pkg::*;
(
  // System clock, reset and clock enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Status register five image
  input wire logic [7:0] status_reg5,
  // Status towards system logic
  output logic continuous_read_mode,
  output logic frame_active,
  output logic read_streaming,
  output logic [7:0] frame_count,
  output logic [15:0] byte_count,
  // Serial link pins; bit 3 io3_hold_pin, 2 io2_protect_pin, 1 SO, 0 SI
  input wire logic sck,
  input wire logic cs_n_pin,
  input wire logic [3:0] quad_io_in,
  output logic [3:0] quad_io_out,
  output logic [3:0] quad_io_oe,
  // Array read port, serial clock domain
  output logic [ARRAY_AW-1:0] mem_addr,
  input wire logic [7:0] mem_rdata
);

  // System domain configuration and reset request
  logic [2:0] dummy_cfg_reg;
  logic align_cfg_reg;
  logic link_rst_reg;

  // Link domain copies of configuration
  logic [2:0] dummy_s;
  logic align_s;
  logic link_rst_s;

  // Link domain engine state
  qxr_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [6:0] cmd_reg;
  logic [19:0] addr_shift_reg;
  logic [3:0] mode_hi_reg;
  logic [7:0] data_byte_reg;
  logic half_reg;
  logic streaming_reg;
  logic [1:0] byte_gray_reg;
  logic cont_mode_reg;
  logic e7_reg;

  // Link domain decode
  logic [7:0] cmd_full;
  logic [23:0] addr_full;
  logic align_now;
  logic [3:0] dmy_last;
  logic [ARRAY_AW-1:0] start_addr;

  // System domain status copies
  logic [4:0] stat_s;
  logic frame_d_reg;
  logic [1:0] byte_seen_reg;
  logic [1:0] byte_pos;

  qxr_io_if io_bus ();

  // Configuration snapshot; held while the clock enable is low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dummy_cfg_reg <= 3'h0;
      align_cfg_reg <= 1'b0;
    end else if (ce) begin
      dummy_cfg_reg <= status_reg5[SR5_DUMMY_MSB:SR5_DUMMY_LSB];
      align_cfg_reg <= status_reg5[SR5_ALIGN_BIT];
    end
  end

  // Reset request level for the link side, which has no reset of its own
  always_ff @(posedge clk) begin
    link_rst_reg <= !rst_b;
  end

  // Config and reset cross on the link clock; safe since they are steady
  qxr_sync2 #(.W(5)) u_to_link (
    .clk(sck),
    .d({link_rst_reg, align_cfg_reg, dummy_cfg_reg}),
    .q({link_rst_s, align_s, dummy_s})
  );

  // Frame decode
  assign cmd_full = {cmd_reg, quad_io_in[0]};
  assign addr_full = {addr_shift_reg, quad_io_in};
  assign align_now = e7_reg | align_s;
  assign dmy_last = dummy_last(dummy_s);
  assign start_addr = align_now ? {addr_full[ARRAY_AW-1:2], 2'b00}
                                : addr_full[ARRAY_AW-1:0];

  // Phase sequencer; chip select high returns it to the start at once
  always_ff @(posedge sck or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      state_reg <= ST_START;
      cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_START: begin
          cnt_reg <= 4'h1;
          state_reg <= cont_mode_reg ? ST_ADDR : ST_CMD;
        end
        ST_CMD: begin
          if (cnt_reg == CMD_LAST_CNT) begin
            cnt_reg <= 4'h0;
            if (cmd_full == CMD_QUAD_READ || cmd_full == CMD_QUAD_READ_ALIGNED) begin
              state_reg <= ST_ADDR;
            end else begin
              state_reg <= ST_IGNORE; // Other commands are not served here
            end
          end else begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end
        end
        ST_ADDR: begin
          if (cnt_reg == ADDR_LAST_CNT) begin
            cnt_reg <= 4'h0;
            state_reg <= ST_DUMMY;
          end else begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end
        end
        ST_DUMMY: begin
          // Relies on the host clocking every dummy clock
          if (cnt_reg >= dmy_last) begin
            cnt_reg <= 4'h0;
            state_reg <= ST_DATA;
          end else begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end
        end
        ST_DATA: begin
          state_reg <= ST_DATA;
        end
        ST_IGNORE: begin
          state_reg <= ST_IGNORE;
        end
        default: begin
          state_reg <= ST_IGNORE;
        end
      endcase
    end
  end

  // Command and address shifters
  always_ff @(posedge sck or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      cmd_reg <= 7'h00;
      addr_shift_reg <= 20'h00000;
      mode_hi_reg <= NIBBLE_RST;
    end else begin
      if (state_reg == ST_START && !cont_mode_reg) begin
        cmd_reg <= {6'h00, quad_io_in[0]};
      end else if (state_reg == ST_CMD) begin
        cmd_reg <= {cmd_reg[5:0], quad_io_in[0]};
      end
      if (state_reg == ST_START && cont_mode_reg) begin
        addr_shift_reg <= {16'h0000, quad_io_in};
      end else if (state_reg == ST_ADDR) begin
        addr_shift_reg <= {addr_shift_reg[15:0], quad_io_in};
      end
      if (state_reg == ST_DUMMY && cnt_reg == 4'h0) begin
        mode_hi_reg <= quad_io_in;
      end
    end
  end

  // Data path: one byte ahead on the array port, two nibbles per byte
  always_ff @(posedge sck or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      mem_addr <= ARRAY_ADDR_FIRST;
      data_byte_reg <= COUNT8_RST;
      half_reg <= 1'b0;
      streaming_reg <= 1'b0;
    end else begin
      if (state_reg == ST_ADDR && cnt_reg == ADDR_LAST_CNT) begin
        mem_addr <= start_addr;
      end else if (state_reg == ST_DUMMY && cnt_reg >= dmy_last) begin
        data_byte_reg <= mem_rdata;
        mem_addr <= next_addr(mem_addr);
        half_reg <= 1'b0;
        streaming_reg <= 1'b1;
      end else if (state_reg == ST_DATA) begin
        half_reg <= ~half_reg;
        if (half_reg) begin
          data_byte_reg <= mem_rdata;
          mem_addr <= next_addr(mem_addr);
        end
      end
    end
  end

  // Bytes as a two-bit gray count; one bit moves per byte, safe to sample
  always_ff @(posedge sck) begin
    if (link_rst_s) begin
      byte_gray_reg <= 2'h0;
    end else if (state_reg == ST_DATA && half_reg) begin
      byte_gray_reg <= {byte_gray_reg[0], ~byte_gray_reg[1]};
    end
  end

  // Persistent mode; survives chip select, cleared by system reset or by a mode byte that ends it
  always_ff @(posedge sck) begin
    if (link_rst_s) begin
      cont_mode_reg <= 1'b0;
      e7_reg <= 1'b0;
    end else begin
      if (state_reg == ST_CMD && cnt_reg == CMD_LAST_CNT) begin
        e7_reg <= (cmd_full == CMD_QUAD_READ_ALIGNED);
      end
      if (state_reg == ST_DUMMY && cnt_reg == MODE_LAST_CNT) begin
        cont_mode_reg <= mode_cont({mode_hi_reg, quad_io_in});
      end
    end
  end

  // Nibble choice and drive for the pad stage
  assign io_bus.nibble = half_reg ? data_byte_reg[3:0] : data_byte_reg[7:4];
  assign io_bus.drive = (state_reg == ST_DATA);

  qxr_io_pad u_pad (
    .sck(sck),
    .cs_n_pin(cs_n_pin),
    .io(io_bus.pad),
    .quad_io_out(quad_io_out),
    .quad_io_oe(quad_io_oe)
  );

  // Status back to the system clock
  qxr_sync2 #(.W(5)) u_to_sys (
    .clk(clk),
    .d({cont_mode_reg, ~cs_n_pin, streaming_reg, byte_gray_reg}),
    .q(stat_s)
  );
  assign byte_pos = {stat_s[1], ^stat_s[1:0]}; // Gray to binary

  // Registered status and event counters
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      continuous_read_mode <= 1'b0;
      frame_active <= 1'b0;
      read_streaming <= 1'b0;
      frame_d_reg <= 1'b0;
      byte_seen_reg <= byte_pos;
      frame_count <= COUNT8_RST;
      byte_count <= COUNT16_RST;
    end else if (ce) begin
      continuous_read_mode <= stat_s[4];
      frame_active <= stat_s[3];
      read_streaming <= stat_s[2];
      frame_d_reg <= stat_s[3];
      byte_seen_reg <= byte_pos;
      if (stat_s[3] && !frame_d_reg) begin
        frame_count <= 8'(frame_count + 8'h01);
      end
      // Up to three bytes per system clock are caught; more are lost
      byte_count <= 16'(byte_count + {14'h0000, 2'(byte_pos - byte_seen_reg)});
    end
  end

  // Checks on the link clock
  property p_cmd_len;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_CMD && cnt_reg == CMD_LAST_CNT) |=> (state_reg != ST_CMD);
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("command phase length wrong");

  property p_addr_len;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_ADDR && cnt_reg == ADDR_LAST_CNT) |=> (state_reg == ST_DUMMY);
  endproperty
  a_addr_len: assert property (p_addr_len) else $error("address phase length wrong");

  property p_align;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_ADDR && cnt_reg == ADDR_LAST_CNT && e7_reg) |=> (mem_addr[1:0] == 2'b00);
  endproperty
  a_align: assert property (p_align) else $error("aligned read kept low address bits");

  property p_dummy_len;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_DUMMY && !$past(state_reg == ST_DUMMY)) |->
        ##1 (state_reg == ST_DUMMY) ##0 (cnt_reg == 4'h1);
  endproperty
  a_dummy_len: assert property (p_dummy_len) else $error("dummy period shorter than two");

  property p_turn;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_DUMMY && cnt_reg == dmy_last) |=> (quad_io_oe == 4'hF);
  endproperty
  a_turn: assert property (p_turn) else $error("lines not driven after dummy");

  property p_upper;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_DATA && !half_reg) |-> (quad_io_out == data_byte_reg[7:4]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper nibble not first");

  property p_lower;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_DATA && half_reg) |-> (quad_io_out == data_byte_reg[3:0]);
  endproperty
  a_lower: assert property (p_lower) else $error("lower nibble not second");

  property p_wrap;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_DATA && half_reg && mem_addr == ARRAY_ADDR_LAST)
        |=> (mem_addr == ARRAY_ADDR_FIRST);
  endproperty
  a_wrap: assert property (p_wrap) else $error("array address did not wrap");

  property p_skip_cmd;
    @(posedge sck) disable iff (cs_n_pin)
      (state_reg == ST_START && cont_mode_reg) |=> (state_reg == ST_ADDR);
  endproperty
  a_skip_cmd: assert property (p_skip_cmd) else $error("continuous frame expected command");

  property p_mode;
    @(posedge sck) disable iff (cs_n_pin || link_rst_s)
      (state_reg == ST_DUMMY && cnt_reg == MODE_LAST_CNT)
        |=> (cont_mode_reg == mode_cont({$past(mode_hi_reg), $past(quad_io_in)}));
  endproperty
  a_mode: assert property (p_mode) else $error("mode byte decode not applied");

endmodule

// >>> qxr_host_model.sv
// Host side model of the quad read link: chip select, serial clock, four lines.
// Assumes the bench resolves each line from the device enables and host_io.
`timescale 1ns/100ps
module qxr_host_model (
  // Link clock and chip select
  output logic sck,
  output logic cs_n_pin,
  // Host drive and resolved line level
  output logic [3:0] host_io,
  input wire logic [3:0] quad_io,
  input wire logic [3:0] quad_io_oe
);
  logic [3:0] got [0:31];
  logic [3:0] oe_pre;
  logic [3:0] oe_any;
  logic [3:0] oe_end;

  // Clock stands low between frames
  initial begin
    sck = 1'b0;
    cs_n_pin = 1'b1;
    host_io = 4'hA;
  end

  // One clock, host nibble set up half a period before the rise
  task automatic tick(input logic [3:0] v);
    host_io = v;
    #6 sck = 1'b1;
    #6 sck = 1'b0;
  endtask

  // Command (optional), address, mode and dummy, then read nibbles
  task automatic frame(input bit with_cmd, input logic [7:0] cmd, input logic [23:0] addr,
                       input logic [7:0] mode, input int dummies, input int nibs);
    cs_n_pin = 1'b0;
    oe_any = 4'h0;
    if (with_cmd) begin
      for (int i = 7; i >= 0; i--) tick({{3{~cmd[i]}}, cmd[i]});
    end
    for (int n = 5; n >= 0; n--) tick(addr[4*n +: 4]);
    for (int d = 0; d < dummies; d++) begin
      if (d == dummies - 1) oe_pre = quad_io_oe;
      tick(d == 0 ? mode[7:4] : d == 1 ? mode[3:0] : ~host_io);
    end
    // Released lines keep toggling so a stale value never passes
    for (int k = 0; k < nibs; k++) begin
      host_io = ~host_io;
      #6 got[k] = quad_io;
      oe_any = oe_any | quad_io_oe;
      sck = 1'b1;
      if (k < nibs - 1) #6 sck = 1'b0;
    end
    // Chip select may rise with the clock high, mid-byte
    #3 cs_n_pin = 1'b1;
    #1 oe_end = quad_io_oe;
    #2 sck = 1'b0;
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the quad continuous read engine.
// Assumes the host model drives the link and a bench function models the array.
`timescale 1ns/100ps
module testbench import qxr_pkg::*;;
  logic clk;
  logic rst_b;
  logic ce;
  logic [7:0] status_reg5;
  logic continuous_read_mode, frame_active, read_streaming;
  logic [7:0] frame_count;
  logic [15:0] byte_count;
  logic sck, cs_n_pin;
  logic [3:0] quad_io, quad_io_out, quad_io_oe, host_io;
  logic [ARRAY_AW-1:0] mem_addr;
  logic [7:0] mem_rdata;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int act_cnt = 0;
  int strm_cnt = 0;
  logic [31:0] seed;
  logic [7:0] exp_frames;
  logic [15:0] exp_bytes;
  logic cont_exp;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Array contents: mixes all address bits so a wrong address shows
  function automatic logic [7:0] array_byte(input logic [ARRAY_AW-1:0] a);
    return a[7:0] ^ a[15:8] ^ {a[18:16], 5'h00} ^ 8'h5A;
  endfunction

  function automatic logic [3:0] exp_nib(input logic [ARRAY_AW-1:0] a, input int k);
    logic [7:0] d;
    d = array_byte(a + ARRAY_AW'(k / 2));
    return k[0] ? d[3:0] : d[7:4];
  endfunction

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Line level from both parties
  assign quad_io = (quad_io_oe & quad_io_out) | (~quad_io_oe & host_io);
  assign mem_rdata = array_byte(mem_addr);

  qxr_read_engine dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .status_reg5(status_reg5),
    .continuous_read_mode(continuous_read_mode), .frame_active(frame_active),
    .read_streaming(read_streaming), .frame_count(frame_count), .byte_count(byte_count),
    .sck(sck), .cs_n_pin(cs_n_pin), .quad_io_in(quad_io), .quad_io_out(quad_io_out),
    .quad_io_oe(quad_io_oe), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  qxr_host_model host_u (.sck(sck), .cs_n_pin(cs_n_pin), .host_io(host_io),
    .quad_io(quad_io), .quad_io_oe(quad_io_oe));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Frame through the host model, then link data and status outputs
  task automatic read_frame(input bit with_cmd, input logic [7:0] cmd, input logic [23:0] addr,
                            input logic [7:0] mode, input int nibs, input bit good);
    logic [ARRAY_AW-1:0] a;
    logic [2:0] c;
    int a0;
    int s0;
    a0 = act_cnt;
    s0 = strm_cnt;
    c = status_reg5[SR5_DUMMY_MSB:SR5_DUMMY_LSB];
    if (c > DUMMY_CODE_MAX) c = DUMMY_CODE_MAX;
    a = addr[ARRAY_AW-1:0];
    if (cmd == CMD_QUAD_READ_ALIGNED || status_reg5[SR5_ALIGN_BIT]) a[1:0] = 2'b00;
    @(negedge clk);
    #7 host_u.frame(with_cmd, cmd, addr, mode, 2 * (int'(c) + 1), nibs);
    if (good) begin
      check(host_u.oe_pre, 4'h0);
      for (int k = 0; k < nibs; k++) check(host_u.got[k], exp_nib(a, k));
      if (ce) exp_bytes = exp_bytes + 16'(nibs / 2);
      cont_exp = (mode[5:4] == 2'b10);
    end else begin
      check(host_u.oe_any, 4'h0);
    end
    check(host_u.oe_end, 4'h0);
    if (ce) exp_frames++;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(frame_count, exp_frames);
    check(byte_count, exp_bytes);
    check(continuous_read_mode, cont_exp);
    // Frame level seen high unless frozen, streaming level only on served frames, and both low now
    check(16'(act_cnt != a0), 16'(ce));
    check(16'(strm_cnt != s0), 16'(good & ce));
    check(16'({frame_active, read_streaming}), 16'h0000);
  endtask

  // Status monitors: clock edges on which each level was seen high
  always @(posedge clk) begin
    if (frame_active === 1'b1) act_cnt <= act_cnt + 1;
    if (read_streaming === 1'b1) strm_cnt <= strm_cnt + 1;
  end

  // Hang guard: whole run is about a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    logic [7:0] cmd;
    logic [7:0] m;
    rst_b = 1'b0;
    ce = 1'b1;
    status_reg5 = 8'h00;
    seed = 32'h0000003C;
    exp_frames = 8'h00;
    exp_bytes = 16'h0000;
    cont_exp = 1'b0;
    // Link reset needs clock edges, so a junk frame runs during reset
    fork
      begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
      end
      #100 host_u.frame(1'b1, 8'h00, 24'h000000, 8'h00, 2, 0);
    join
    repeat (4) @(posedge clk);
    seed = xorshift(seed);
    cmd = seed[7:0];
    if (cmd == CMD_QUAD_READ || cmd == CMD_QUAD_READ_ALIGNED) cmd = cmd ^ 8'h01;
    read_frame(1'b1, cmd, seed[31:8], 8'hFF, 4, 1'b0);
    $display("Test refused command done");
    read_frame(1'b1, CMD_QUAD_READ, {seed[23:19], 19'h7FFFE}, 8'hFF, 8, 1'b1);
    $display("Test array wrap done");
    // Dummy codes 0 to 5 incl. clamped 5, both flag values, both commands
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      @(posedge clk);
      status_reg5 <= {seed[7], 3'(i % 6), seed[3:1], 1'((i / 6) % 2)};
      repeat (4) @(posedge clk);
      cmd = (i < 12) ? CMD_QUAD_READ : CMD_QUAD_READ_ALIGNED;
      m = {seed[15:14], 2'b10, seed[11:8]};
      read_frame(1'b1, cmd, seed[31:8], m, 6, 1'b1);
      seed = xorshift(seed);
      m = seed[15:8];
      if (m[5:4] == 2'b10) m[5:4] = 2'b01;
      read_frame(1'b0, cmd, seed[31:8], m, 5, 1'b1);
      $display("Test combination %0d done", i);
    end
    // Clock enable low holds system state while the link still serves
    @(posedge clk);
    ce <= 1'b0;
    read_frame(1'b1, CMD_QUAD_READ, 24'h03FFF0, 8'h00, 4, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    exp_bytes = exp_bytes + 16'h0002;
    check(byte_count, exp_bytes);
    check(frame_count, exp_frames);
    $display("Test clock enable hold done");
    summarize();
  end
endmodule
